// file: core/sgtlb_defines.svh
// Purpose: Offsets, field positions, widths and reset values of the translation-buffer status registers
// Assumes: 64-bit register port, one register per aligned 8-byte word
// Notes: Definitions only; include by bare name
`ifndef SGTLB_DEFINES_SVH
`define SGTLB_DEFINES_SVH

// Register byte offsets on the 8-bit address port
`define OFF_BYPASS 8'h00
`define OFF_PRV 8'h08
`define OFF_IVA 8'h10
`define OFF_ENTRY0 8'h18
`define ENTRY_STRIDE 8'h08

// Field widths
`define ADDR_W 8
`define DATA_W 64
`define TAG_W 30
`define PFN_W 18
`define BYP_W 18
`define PRV_W 8
`define IVA_W 18
`define IDX_W 3

// Field positions inside the readout words
`define BYP_VALID_BIT 0
`define BYP_DATA_LSB 1
`define PRV_LSB 0
`define IVA_LSB 32
`define TAG_LSB 0
`define VALID_BIT 32
`define PFN_LSB 33

// Default entry count and its limit given by the index width
`define ENTRIES_DEF 3
`define ENTRIES_MAX 8

// Reset values
`define PRV_RST 8'h00
`define IVA_RST 18'h00000
`define BYP_RST 18'h00000
`define DATA_RST 64'h0000000000000000

`endif

// file: core/sgtlb_pkg.sv
// Purpose: Shared types of the translation-buffer status registers
// Assumes: Constants come from sgtlb_defines.svh
// Notes: Types only
`default_nettype none
`include "sgtlb_defines.svh"

package sgtlb_pkg;

	// One translation buffer entry as the readout shows it
	typedef struct packed {
		logic valid;
		logic [`PFN_W-1:0] pfn;
		logic [`TAG_W-1:0] tag;
	} entry_t;

	// Whole state of the top register block
	typedef struct packed {
		logic [`PRV_W-1:0] prv;
		logic [`IVA_W-1:0] iva;
		logic [`DATA_W-1:0] rdata;
	} top_state_t;

	// Whole state of the bypass holding register
	typedef struct packed {
		logic valid;
		logic [`BYP_W-1:0] data;
	} hold_state_t;

endpackage : sgtlb_pkg

`default_nettype wire

// file: core/tlb_side_if.sv
// Purpose: Carries entry updates, bypass loads and their readouts between the register block and its stores
// Assumes: One clock; all signals sampled on CLK
// Notes: The ctl end drives updates, the store and hold ends answer with their contents
`timescale 1ns/100ps
`default_nettype none
`include "sgtlb_defines.svh"

interface tlb_side_if #(parameter int ENTRIES = `ENTRIES_DEF) ();
	logic wr; // Entry update strobe
	logic [`IDX_W-1:0] idx; // Entry being updated
	sgtlb_pkg::entry_t wdata; // New entry contents
	sgtlb_pkg::entry_t [ENTRIES-1:0] table_q; // Current entry contents
	logic byp_ld; // Bypass load strobe
	logic byp_clr; // Bypass release strobe
	logic [`BYP_W-1:0] byp_data; // Fetched map entry
	logic byp_valid; // Bypass holding valid
	logic [`BYP_W-1:0] byp_q; // Bypass holding data

	modport ctl (output wr, idx, wdata, byp_ld, byp_clr, byp_data, input table_q, byp_valid, byp_q);
	modport store (input wr, idx, wdata, output table_q);
	modport hold (input byp_ld, byp_clr, byp_data, output byp_valid, byp_q);
endinterface : tlb_side_if

`default_nettype wire

// file: core/tlb_entry_store.sv
// Purpose: Flip-flop copy of the translation buffer entries that software may read
// Assumes: Updates come only from the bus interface logic through the store modport
// Notes: No path from the register port reaches this storage
`timescale 1ns/100ps
`default_nettype none
`include "sgtlb_defines.svh"

module tlb_entry_store #(parameter int ENTRIES = `ENTRIES_DEF) (
	input wire logic clk,
	input wire logic resetn,
	tlb_side_if.store side
);
	// Whole state is the entry array
	typedef struct packed {
		sgtlb_pkg::entry_t [ENTRIES-1:0] ent;
	} store_state_t;

	store_state_t st_reg; // Registered entries
	store_state_t st_next; // Next entries

	// Only the bus interface update strobe changes an entry
	always_comb
	begin
		st_next = st_reg;
		if (side.wr && (int'(side.idx) < ENTRIES))
		begin
			st_next.ent[side.idx] = side.wdata;
		end
	end

	// Register the state; synchronous reset clears every entry
	always_ff @(posedge clk)
	begin
		if (!resetn)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign side.table_q = st_reg.ent;

	// Without an update strobe the entries never move
	chk_entry_hold: assert property (@(posedge clk) disable iff (!resetn)
		!side.wr |=> $stable(st_reg.ent))
		else $error("entry changed without update strobe");
endmodule : tlb_entry_store

`default_nettype wire

// file: core/bypass_holder.sv
// Purpose: Holding register for map entries fetched while the translation buffer is off
// Assumes: Load and release strobes come from the bus interface logic only
// Notes: A load in the same cycle as a release wins, so no fetched entry is lost
`timescale 1ns/100ps
`default_nettype none
`include "sgtlb_defines.svh"

module bypass_holder (
	input wire logic clk,
	input wire logic resetn,
	tlb_side_if.hold side
);
	sgtlb_pkg::hold_state_t st_reg; // Registered holding state
	sgtlb_pkg::hold_state_t st_next; // Next holding state

	// Load sets valid and data; release only drops valid
	always_comb
	begin
		st_next = st_reg;
		if (side.byp_ld)
		begin
			st_next.valid = 1'b1;
			st_next.data = side.byp_data;
		end
		else if (side.byp_clr)
		begin
			st_next.valid = 1'b0;
		end
	end

	// Register the state; synchronous reset
	always_ff @(posedge clk)
	begin
		if (!resetn)
			st_reg <= '{valid: 1'b0, data: `BYP_RST};
		else
			st_reg <= st_next;
	end

	assign side.byp_valid = st_reg.valid;
	assign side.byp_q = st_reg.data;

	// A load shows valid with the fetched entry one cycle later
	chk_bypass_load: assert property (@(posedge clk) disable iff (!resetn)
		side.byp_ld |=> st_reg.valid && (st_reg.data == $past(side.byp_data)))
		else $error("bypass load not captured");
endmodule : bypass_holder

`default_nettype wire

// file: core/sgtlb_regs.sv
// Purpose: Software-visible translation buffer status and interrupt vector registers of the I/O bridge
// Assumes: Plain register port with read data one cycle after the read strobe; one 250 MHz clock
// Notes: Only the passive release vector is software writable; all other writes are accepted and dropped
`timescale 1ns/100ps
`default_nettype none
`include "sgtlb_defines.svh"

//Contract
// - Bypass register: valid bit0, data 18:1
// - TLB off: fetched map entry loads bypass
// - Bypass writes accepted, contents unchanged
// - Passive release vector in bits 7:0
// - Passive release bits 31:8 read zero
// - Vector address 22:5 shown in 49:32
// - Interrupt address bits 63:50 read zero
// - Entry readout: tag 29:0, valid 32, frame 50:33
// - Entry writes accepted, buffer unchanged
module sgtlb_regs #(
	parameter int ENTRIES = `ENTRIES_DEF // Entries with a readout register
) (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [`ADDR_W-1:0] ADDR,
	input wire logic [`DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [`DATA_W-1:0] RDATA,
	output logic [`PRV_W-1:0] PASSIVE_VECTOR,
	input wire logic TLB_OFF,
	input wire logic MAP_LOAD,
	input wire logic [`BYP_W-1:0] MAP_DATA,
	input wire logic BYPASS_DONE,
	input wire logic ENTRY_WR,
	input wire logic [`IDX_W-1:0] ENTRY_IDX,
	input wire logic [`TAG_W-1:0] ENTRY_TAG,
	input wire logic ENTRY_VALID,
	input wire logic [`PFN_W-1:0] ENTRY_PFN,
	input wire logic IV_ACCESS,
	input wire logic [`IVA_W-1:0] IV_ADDR
);
	// Refuse entry counts the index and address map cannot serve
	// Eight entries fill the three-bit index; more would need a wider index
	if (ENTRIES < 1 || ENTRIES > `ENTRIES_MAX)
	begin : g_bad_entries
		$error("ENTRIES must lie between 1 and 8");
	end

	// Updates travel down and contents come back up; the register port never drives it
	tlb_side_if #(.ENTRIES(ENTRIES)) side (); // Link to the two stores

	sgtlb_pkg::top_state_t st_reg; // Registered block state
	sgtlb_pkg::top_state_t st_next; // Next block state

	logic [`DATA_W-1:0] entry_word [ENTRIES]; // Readout word per entry
	logic [ENTRIES-1:0] entry_hit; // Address matches entry readout
	logic [`DATA_W-1:0] byp_word; // Bypass readout word
	logic [`DATA_W-1:0] prv_word; // Passive release readout word
	logic [`DATA_W-1:0] iva_word; // Interrupt address readout word

	// Forward bus interface events into the stores
	assign side.wr = ENTRY_WR;
	assign side.idx = ENTRY_IDX;
	assign side.wdata = '{valid: ENTRY_VALID, pfn: ENTRY_PFN, tag: ENTRY_TAG};
	// A fetch only parks in the bypass register while the buffer is off
	assign side.byp_ld = MAP_LOAD && TLB_OFF;
	assign side.byp_clr = BYPASS_DONE;
	assign side.byp_data = MAP_DATA;

	// Entry storage; the register port has no path into it
	// Updates aimed past the last entry are dropped inside the store
	tlb_entry_store #(.ENTRIES(ENTRIES)) u_store (
		.clk(CLK),
		.resetn(RESETN),
		.side(side.store)
	);

	// Bypass holding register, loaded only by the bus interface
	// Nothing here guards a read during a bridge fetch; software must avoid it
	bypass_holder u_hold (
		.clk(CLK),
		.resetn(RESETN),
		.side(side.hold)
	);

	// Bypass word: valid in bit 0, data above it, rest zero
	always_comb
	begin
		byp_word = `DATA_RST;
		byp_word[`BYP_VALID_BIT] = side.byp_valid;
		byp_word[`BYP_DATA_LSB +: `BYP_W] = side.byp_q;
	end

	// Passive release word: reserved bits stay zero
	always_comb
	begin
		prv_word = `DATA_RST;
		prv_word[`PRV_LSB +: `PRV_W] = st_reg.prv;
	end

	// Interrupt address word: field in 49:32, all else zero
	always_comb
	begin
		iva_word = `DATA_RST;
		iva_word[`IVA_LSB +: `IVA_W] = st_reg.iva;
	end

	// One readout word and address match per entry
	for (genvar i = 0; i < ENTRIES; i++)
	begin : g_entry
		always_comb
		begin
			entry_word[i] = `DATA_RST;
			entry_word[i][`TAG_LSB +: `TAG_W] = side.table_q[i].tag;
			entry_word[i][`VALID_BIT] = side.table_q[i].valid;
			entry_word[i][`PFN_LSB +: `PFN_W] = side.table_q[i].pfn;
		end
		assign entry_hit[i] = (ADDR == 8'(`OFF_ENTRY0 + `ENTRY_STRIDE * 8'(i)));
		// Every readout shows its own entry's fields, rest zero
		chk_entry_fields: assert property (@(posedge CLK) disable iff (!RESETN)
			RD && entry_hit[i] |=> (RDATA[29:0] == $past(side.table_q[i].tag))
				&& (RDATA[32] == $past(side.table_q[i].valid))
				&& (RDATA[50:33] == $past(side.table_q[i].pfn))
				&& (RDATA[63:51] == 13'h0) && (RDATA[31:30] == 2'h0))
			else $error("entry readout fields wrong");
		// An update to this entry shows in its readout source next cycle
		chk_entry_update: assert property (@(posedge CLK) disable iff (!RESETN)
			ENTRY_WR && (int'(ENTRY_IDX) == i) |=> side.table_q[i] == $past(side.wdata))
			else $error("entry update not stored");
	end

	// Register map on the byte address, one 64-bit word every 8 bytes:
	//   0x00 bypass holding word, read only
	//   0x08 passive release vector, the only writable field
	//   0x10 interrupt vector address, loaded by hardware only
	//   0x18 onward one readout word per entry, read only
	// Addresses outside the map read zero and ignore writes, so software
	// probing past the last entry never sees stale data
	// Read data are registered: one cycle of latency is traded for an
	// RDATA that comes straight from a flip-flop
	// Next state: register writes, vector capture and read data
	always_comb
	begin
		st_next = st_reg;
		// Hardware captures the vector address on each vector access
		// A read in the same cycle still returns the previous address
		if (IV_ACCESS)
		begin
			st_next.iva = IV_ADDR;
		end
		// Only the passive release field takes software writes;
		// bypass and entry writes fall through with no effect and no error
		if (WR && (ADDR == `OFF_PRV))
		begin
			st_next.prv = WDATA[`PRV_LSB +: `PRV_W];
		end
		// Read data stands for exactly the cycle after the strobe
		st_next.rdata = `DATA_RST;
		if (RD)
		begin
			case (ADDR)
				`OFF_BYPASS: st_next.rdata = byp_word;
				`OFF_PRV: st_next.rdata = prv_word;
				`OFF_IVA: st_next.rdata = iva_word;
				default:
				begin
					// Addresses outside the map leave rdata at zero
					// Entry readouts; reading never touches the stores
					for (int i = 0; i < ENTRIES; i++)
					begin
						if (entry_hit[i])
							st_next.rdata = entry_word[i];
					end
				end
			endcase
		end
	end

	// Register the state; synchronous reset
	// Every register starts at zero; no other start value is defined
	always_ff @(posedge CLK)
	begin
		if (!RESETN)
			st_reg <= '{prv: `PRV_RST, iva: `IVA_RST, rdata: `DATA_RST};
		else
			st_reg <= st_next;
	end

	// Outputs come straight from flip-flops
	assign RDATA = st_reg.rdata;
	assign PASSIVE_VECTOR = st_reg.prv;

	// Bypass read shows valid and data at their bit positions
	chk_bypass_layout: assert property (@(posedge CLK) disable iff (!RESETN)
		RD && (ADDR == `OFF_BYPASS) |=> (RDATA[`BYP_VALID_BIT] == $past(side.byp_valid))
			&& (RDATA[`BYP_DATA_LSB +: `BYP_W] == $past(side.byp_q))
			&& (RDATA[63:19] == 45'h0))
		else $error("bypass readout layout wrong");

	// A fetch with the buffer on leaves the bypass register alone
	chk_bypass_gate: assert property (@(posedge CLK) disable iff (!RESETN)
		MAP_LOAD && !TLB_OFF && !BYPASS_DONE |=> $stable(side.byp_q) && $stable(side.byp_valid))
		else $error("bypass loaded while buffer enabled");

	// Software write to the bypass register changes nothing
	chk_bypass_ro: assert property (@(posedge CLK) disable iff (!RESETN)
		WR && (ADDR == `OFF_BYPASS) && !side.byp_ld && !side.byp_clr |=> $stable(side.byp_q)
			&& $stable(side.byp_valid))
		else $error("bypass changed by software write");

	// Written vector appears on the output and reads back
	chk_prv_write: assert property (@(posedge CLK) disable iff (!RESETN)
		WR && (ADDR == `OFF_PRV) ##1 RD && (ADDR == `OFF_PRV) |=> RDATA[7:0] == $past(WDATA[7:0], 2)
			&& PASSIVE_VECTOR == $past(WDATA[7:0], 2))
		else $error("passive release vector not written");

	// Reserved passive release bits read as zero
	chk_prv_reserved: assert property (@(posedge CLK) disable iff (!RESETN)
		RD && (ADDR == `OFF_PRV) |=> RDATA[63:8] == 56'h0)
		else $error("passive release reserved bits nonzero");

	// Vector access address lands in bits 49:32 of the next read
	chk_iva_load: assert property (@(posedge CLK) disable iff (!RESETN)
		IV_ACCESS ##1 (RD && (ADDR == `OFF_IVA) && !IV_ACCESS) |=> RDATA[49:32] == $past(IV_ADDR, 2))
		else $error("vector address not captured");

	// Interrupt address reserved bits read as zero
	chk_iva_reserved: assert property (@(posedge CLK) disable iff (!RESETN)
		RD && (ADDR == `OFF_IVA) |=> (RDATA[63:50] == 14'h0) && (RDATA[31:0] == 32'h0))
		else $error("interrupt address reserved bits nonzero");

	// Entry 0 readout has tag, valid and frame at their places
	chk_entry_layout: assert property (@(posedge CLK) disable iff (!RESETN)
		RD && (ADDR == `OFF_ENTRY0) |=> (RDATA[29:0] == $past(side.table_q[0].tag))
			&& (RDATA[32] == $past(side.table_q[0].valid))
			&& (RDATA[50:33] == $past(side.table_q[0].pfn))
			&& (RDATA[63:51] == 13'h0) && (RDATA[31:30] == 2'h0))
		else $error("entry readout layout wrong");

	// Software write to an entry readout leaves the buffer alone
	chk_entry_ro: assert property (@(posedge CLK) disable iff (!RESETN)
		WR && (|entry_hit) && !ENTRY_WR |=> $stable(side.table_q))
		else $error("buffer changed by software write");

	// Reads never disturb buffer or bypass state
	chk_read_quiet: assert property (@(posedge CLK) disable iff (!RESETN)
		RD && !ENTRY_WR && !side.byp_ld && !side.byp_clr |=> $stable(side.table_q)
			&& $stable(side.byp_q) && $stable(side.byp_valid))
		else $error("read changed buffer state");

	// A passive release write reaches the output pin one cycle later
	chk_prv_output: assert property (@(posedge CLK) disable iff (!RESETN)
		WR && (ADDR == `OFF_PRV) |=> PASSIVE_VECTOR == $past(WDATA[7:0]))
		else $error("passive release output not updated");

	// Without a write to its address the vector holds
	chk_prv_hold: assert property (@(posedge CLK) disable iff (!RESETN)
		!(WR && (ADDR == `OFF_PRV)) |=> $stable(PASSIVE_VECTOR))
		else $error("passive release vector moved without write");

	// A passive release read returns the vector the pin shows
	chk_prv_read: assert property (@(posedge CLK) disable iff (!RESETN)
		RD && (ADDR == `OFF_PRV) |=> RDATA[7:0] == $past(PASSIVE_VECTOR))
		else $error("passive release readback wrong");

	// Each vector access captures its address bits
	chk_iva_capture: assert property (@(posedge CLK) disable iff (!RESETN)
		IV_ACCESS |=> st_reg.iva == $past(IV_ADDR))
		else $error("vector address not loaded");

	// Only a vector access moves the address field; software writes do not
	chk_iva_hold: assert property (@(posedge CLK) disable iff (!RESETN)
		!IV_ACCESS |=> $stable(st_reg.iva))
		else $error("vector address moved without access");

	// An interrupt address read returns the captured field
	chk_iva_read: assert property (@(posedge CLK) disable iff (!RESETN)
		RD && (ADDR == `OFF_IVA) |=> RDATA[49:32] == $past(st_reg.iva))
		else $error("vector address readback wrong");

	// A fetch with the buffer off parks the entry as valid
	chk_bypass_fetch: assert property (@(posedge CLK) disable iff (!RESETN)
		MAP_LOAD && TLB_OFF |=> side.byp_valid && (side.byp_q == $past(MAP_DATA)))
		else $error("fetched map entry not parked");

	// A release without a new fetch drops the valid flag
	chk_bypass_release: assert property (@(posedge CLK) disable iff (!RESETN)
		BYPASS_DONE && !(MAP_LOAD && TLB_OFF) |=> !side.byp_valid)
		else $error("bypass valid not released");

	// Read data stand only in the cycle after a read strobe
	chk_rdata_idle: assert property (@(posedge CLK) disable iff (!RESETN)
		!RD |=> RDATA == `DATA_RST)
		else $error("read data left standing");

	// Addresses outside the map read as zero
	chk_unmapped_zero: assert property (@(posedge CLK) disable iff (!RESETN)
		RD && (ADDR != `OFF_BYPASS) && (ADDR != `OFF_PRV) && (ADDR != `OFF_IVA) && !(|entry_hit)
			|=> RDATA == `DATA_RST)
		else $error("unmapped read not zero");

	// Software writes never move buffer or bypass state
	chk_write_quiet: assert property (@(posedge CLK) disable iff (!RESETN)
		WR && !ENTRY_WR && !side.byp_ld && !side.byp_clr |=> $stable(side.table_q)
			&& $stable(side.byp_q) && $stable(side.byp_valid))
		else $error("write changed buffer state");
endmodule : sgtlb_regs

`default_nettype wire

// file: sim/bus_logic_model.sv
// Purpose: Stands in for the bridge bus interface logic that feeds the status registers
// Assumes: Each task starts in the time step of a rising clk edge and returns on one
// Notes: Data lines show the inverse of their last value once a strobe is over, so stale data never looks valid
`timescale 1ns/100ps
`default_nettype none
`include "sgtlb_defines.svh"

module bus_logic_model (
	input wire logic clk,
	output logic tlb_off,
	output logic map_load,
	output logic [`BYP_W-1:0] map_data,
	output logic bypass_done,
	output logic entry_wr,
	output logic [`IDX_W-1:0] entry_idx,
	output logic [`TAG_W-1:0] entry_tag,
	output logic entry_valid,
	output logic [`PFN_W-1:0] entry_pfn,
	output logic iv_access,
	output logic [`IVA_W-1:0] iv_addr
);
	// Quiet bus at time zero
	initial
	begin
		{tlb_off, map_load, map_data, bypass_done, entry_wr, entry_idx} = '0;
		{entry_tag, entry_valid, entry_pfn, iv_access, iv_addr} = '0;
	end

	// Map fetch with optional load and release in one cycle; tlb_off stays as a level
	task automatic map(input logic off, input logic ld, input logic [`BYP_W-1:0] d, input logic done);
		tlb_off <= off;
		map_load <= ld;
		map_data <= d;
		bypass_done <= done;
		@(posedge clk);
		map_load <= 1'b0;
		bypass_done <= 1'b0;
		map_data <= ~d;
	endtask : map

	// Translation buffer entry update
	task automatic entry(input logic [`IDX_W-1:0] i, input logic [`TAG_W-1:0] t, input logic v,
		input logic [`PFN_W-1:0] p);
		entry_wr <= 1'b1;
		entry_idx <= i;
		{entry_tag, entry_valid, entry_pfn} <= {t, v, p};
		@(posedge clk);
		entry_wr <= 1'b0;
		{entry_tag, entry_valid, entry_pfn} <= ~{t, v, p};
		// Idle edge so a following update never re-raises the strobe in this step
		@(posedge clk);
	endtask : entry

	// Interrupt vector access carrying processor address bits 22:5
	task automatic iv(input logic [`IVA_W-1:0] a);
		iv_access <= 1'b1;
		iv_addr <= a;
		@(posedge clk);
		iv_access <= 1'b0;
		iv_addr <= ~a;
	endtask : iv
endmodule : bus_logic_model

`default_nettype wire

// file: sim/testbench.sv
// Purpose: Self-checking bench for the translation buffer status registers
// Assumes: Three entries; every task starts and ends in the time step of a rising CLK edge
// Notes: RDATA is taken at the edge closing its cycle, before that edge's updates land
`timescale 1ns/100ps
`default_nettype none
`include "sgtlb_defines.svh"
`define CHECK(g, e) check_eq(64'(g), 64'(e))

module testbench;
	logic CLK, RESETN, WR, RD; // Clock, reset and strobes
	logic [`ADDR_W-1:0] ADDR; // Register address
	logic [`DATA_W-1:0] WDATA, RDATA, d; // Port data and last read word
	logic [`PRV_W-1:0] PASSIVE_VECTOR; // Vector level output
	logic TLB_OFF, MAP_LOAD, BYPASS_DONE, ENTRY_WR, ENTRY_VALID, IV_ACCESS; // Bus logic strobes
	logic [`BYP_W-1:0] MAP_DATA; // Fetched map entry
	logic [`IDX_W-1:0] ENTRY_IDX; // Entry index
	logic [`TAG_W-1:0] ENTRY_TAG; // Entry tag
	logic [`PFN_W-1:0] ENTRY_PFN; // Entry frame
	logic [`IVA_W-1:0] IV_ADDR; // Vector address
	logic [63:0] ex [0:2]; // Expected entry words
	int n_mismatch = 0, total_checks = 0, cycles = 0, i;

	sgtlb_regs #(.ENTRIES(3)) uut (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
		.RDATA(RDATA), .PASSIVE_VECTOR(PASSIVE_VECTOR), .TLB_OFF(TLB_OFF), .MAP_LOAD(MAP_LOAD),
		.MAP_DATA(MAP_DATA), .BYPASS_DONE(BYPASS_DONE), .ENTRY_WR(ENTRY_WR), .ENTRY_IDX(ENTRY_IDX),
		.ENTRY_TAG(ENTRY_TAG), .ENTRY_VALID(ENTRY_VALID), .ENTRY_PFN(ENTRY_PFN), .IV_ACCESS(IV_ACCESS),
		.IV_ADDR(IV_ADDR));

	bus_logic_model far_end (.clk(CLK), .tlb_off(TLB_OFF), .map_load(MAP_LOAD), .map_data(MAP_DATA),
		.bypass_done(BYPASS_DONE), .entry_wr(ENTRY_WR), .entry_idx(ENTRY_IDX), .entry_tag(ENTRY_TAG),
		.entry_valid(ENTRY_VALID), .entry_pfn(ENTRY_PFN), .iv_access(IV_ACCESS), .iv_addr(IV_ADDR));

	// 250 MHz clock
	initial
	begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end

	// Hang guard: the tests need under a hundred cycles
	always @(posedge CLK)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_mismatch++;
			stop_test();
		end
	end

	// Verdict and end of run
	task automatic stop_test();
		if (n_mismatch == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test

	// Compare and count
	task automatic check_eq(input logic [63:0] g, input logic [63:0] e);
		total_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask : check_eq

	// One-cycle write
	task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] v);
		WR <= 1'b1;
		ADDR <= a;
		WDATA <= v;
		@(posedge CLK);
		WR <= 1'b0;
	endtask : wr

	// One-cycle read; data stand only in the following cycle
	task automatic rd(input logic [`ADDR_W-1:0] a, output logic [`DATA_W-1:0] v);
		RD <= 1'b1;
		ADDR <= a;
		@(posedge CLK);
		RD <= 1'b0;
		@(posedge CLK);
		v = RDATA;
	endtask : rd

	// Main sequence
	initial
	begin
		{RESETN, WR, RD, ADDR, WDATA} = '0;
		repeat (2) @(posedge CLK);
		RESETN <= 1'b1;
		@(posedge CLK);
		// Everything clears on reset; 0x30 is past the last entry
		for (i = 0; i < 7; i++)
		begin
			rd(8'(8 * i), d);
			`CHECK(d, 64'h0);
		end
		// Passive release vector, upper bits written as ones, read right after the write
		wr(8'h08, 64'hFFFFFFFFFFFFFFA5);
		rd(8'h08, d);
		`CHECK(d, 64'hA5);
		`CHECK(PASSIVE_VECTOR, 8'hA5);
		wr(8'h08, 64'h000000005A5A5A5A);
		rd(8'h08, d);
		`CHECK(d, 64'h5A);
		// Read data do not linger past their cycle
		@(posedge CLK);
		`CHECK(RDATA, 64'h0);
		// Interrupt vector address at all ones and at one; software writes dropped
		far_end.iv(18'h3FFFF);
		rd(8'h10, d);
		`CHECK(d, {14'h0, 18'h3FFFF, 32'h0});
		wr(8'h10, 64'hFFFFFFFFFFFFFFFF);
		rd(8'h10, d);
		`CHECK(d, {14'h0, 18'h3FFFF, 32'h0});
		far_end.iv(18'h00001);
		rd(8'h10, d);
		`CHECK(d, {14'h0, 18'h00001, 32'h0});
		// Bypass is read only while the bus logic model is idle
		far_end.map(1'b0, 1'b1, 18'h3FFFF, 1'b0);
		rd(8'h00, d);
		`CHECK(d, 64'h0);
		far_end.map(1'b1, 1'b1, 18'h2AAAB, 1'b0);
		rd(8'h00, d);
		`CHECK(d, {45'h0, 18'h2AAAB, 1'b1});
		wr(8'h00, 64'hFFFFFFFFFFFFFFFF);
		rd(8'h00, d);
		`CHECK(d, {45'h0, 18'h2AAAB, 1'b1});
		far_end.map(1'b1, 1'b0, 18'h00000, 1'b1);
		rd(8'h00, d);
		`CHECK(d[0], 1'b0);
		far_end.map(1'b1, 1'b1, 18'h15554, 1'b1);
		rd(8'h00, d);
		`CHECK(d, {45'h0, 18'h15554, 1'b1});
		// Entry readouts; an update past the last entry must be ignored
		for (i = 0; i < 3; i++)
		begin
			far_end.entry(3'(i), 30'h2AAAAAA0 + 30'(i), ~i[0], 18'h3FFF0 + 18'(i));
			ex[i] = {13'h0, 18'h3FFF0 + 18'(i), ~i[0], 2'h0, 30'h2AAAAAA0 + 30'(i)};
		end
		far_end.entry(3'd3, 30'h3FFFFFFF, 1'b1, 18'h3FFFF);
		for (i = 0; i < 3; i++)
		begin
			rd(8'(24 + 8 * i), d);
			`CHECK(d, ex[i]);
			wr(8'(24 + 8 * i), ~ex[i]);
			rd(8'(24 + 8 * i), d);
			`CHECK(d, ex[i]);
			rd(8'(24 + 8 * i), d);
			`CHECK(d, ex[i]);
		end
		rd(8'h30, d);
		`CHECK(d, 64'h0);
		// Reset in mid-run clears every register that now holds a value
		RESETN <= 1'b0;
		repeat (2) @(posedge CLK);
		RESETN <= 1'b1;
		@(posedge CLK);
		`CHECK(PASSIVE_VECTOR, 8'h00);
		for (i = 0; i < 7; i++)
		begin
			rd(8'(8 * i), d);
			`CHECK(d, 64'h0);
		end
		stop_test();
	end
endmodule : testbench

`default_nettype wire
